// ===== verilog/sadc_consts.svh
// Purpose: Numeric constants of the SAR frame sequencer
// Assumes: clk_sys at 100 MHz
// Notes:   Edge numbers count serial clock falling edges in a frame
`ifndef SADC_CONSTS_SVH
`define SADC_CONSTS_SVH
// ==========================================================
// Frame edge numbers
`define SADC_FALL_CONV      6'h10
`define SADC_FALL_SHORT_MAX 6'h1D
`define SADC_FALL_LONG      6'h1E
`define SADC_FALL_SAT       6'h3F
// ==========================================================
// Timing
`define SADC_CLK_NS         10
`define SADC_WAKE_NS        1000
`define SADC_WAKE_CYC       ((`SADC_WAKE_NS + `SADC_CLK_NS - 1) / `SADC_CLK_NS)
`endif

// ===== verilog/sadc_pkg.sv
// Purpose: Types shared by the frame sequencer modules
// Assumes: nothing
// Notes:   One-hot state codes
package sadc_pkg;
  // ==========================================================
  // Frame length mode
  typedef enum logic [1:0] {
    SADC_SHORT = 2'h1,
    SADC_LONG  = 2'h2
  } sadc_mode_e;
  // ==========================================================
  // Power state
  typedef enum logic [2:0] {
    SADC_ON     = 3'h1,
    SADC_DOWN   = 3'h2,
    SADC_WAKING = 3'h4
  } sadc_pwr_e;
endpackage

// ===== verilog/sadc_ctl_if.sv
// Purpose: Internal links from the sequencer to shifter and power unit
// Assumes: single clock domain
// Notes:   None
`timescale 1ns/100ps
interface sadc_ctl_if #(parameter int W = 16);
  logic         load;
  logic         shift;
  logic [W-1:0] word;
  logic         bitOut;
  logic         pdEnter;
  logic         wake;
  logic         pdState;
  logic         ready;
  modport ctrl    (output load, shift, word, pdEnter, wake, input bitOut, pdState, ready);
  modport shifter (input load, shift, word, output bitOut);
  modport power   (input pdEnter, wake, output pdState, ready);
endinterface

// ===== verilog/sadc_shifter.sv
// Purpose: Output word shift register, MSB first
// Assumes: load wins over shift
// Notes:   Zeros fill in behind the word
`timescale 1ns/100ps
module sadc_shifter #(
  parameter int W = 16
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  sadc_ctl_if.shifter ctl
);
  logic [W-1:0] shReg;

  // ==========================================================
  // Shift register
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      shReg <= '0;
    else if (ctl.load)
      shReg <= ctl.word;
    else if (ctl.shift)
      shReg <= {shReg[W-2:0], 1'b0};
  end

  // Shifter output bit is always the register MSB; the top registers it onto the pin
  assign ctl.bitOut = shReg[W-1];
endmodule

// ===== verilog/sadc_power.sv
// Purpose: Power-down state and wake-up timer
// Assumes: clk_sys at 100 MHz
// Notes:   ready stays low for the whole warm-up time
`timescale 1ns/100ps
`include "sadc_consts.svh"
module sadc_power #(
  parameter int WAKE_CYC = `SADC_WAKE_CYC
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Control
  sadc_ctl_if.power ctl
);
  sadc_pkg::sadc_pwr_e state;
  logic [11:0]         wakeCnt;
  logic                readyReg;

  // ==========================================================
  // Power state machine
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      state   <= sadc_pkg::SADC_ON;
      wakeCnt <= '0;
    end
    else
    begin
      case (state)
        sadc_pkg::SADC_ON:
        begin
          if (ctl.pdEnter)
            state <= sadc_pkg::SADC_DOWN;
        end
        sadc_pkg::SADC_DOWN:
        begin
          if (ctl.wake)
          begin
            state   <= sadc_pkg::SADC_WAKING;
            wakeCnt <= 12'(WAKE_CYC - 1);
          end
        end
        sadc_pkg::SADC_WAKING:
        begin
          if (ctl.pdEnter)
            state <= sadc_pkg::SADC_DOWN;
          else if (wakeCnt == '0)
            state <= sadc_pkg::SADC_ON;
          else
            wakeCnt <= wakeCnt - 12'h001;
        end
        default:
          state <= sadc_pkg::SADC_ON;
      endcase
    end
  end

  // Ready flag registered so the top sees a clean level
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      readyReg <= 1'b1;
    else
      readyReg <= (state == sadc_pkg::SADC_ON) && !ctl.pdEnter;
  end

  assign ctl.pdState = (state == sadc_pkg::SADC_DOWN);
  assign ctl.ready   = readyReg;
endmodule

// ===== verilog/sadc_frame_ctrl.sv
// Purpose: Serial frame and conversion sequencer of a 14-bit SAR converter
// Assumes: csN, sclk and the request pin are synchronous to clk_sys
// Notes:   Edges of csN and sclk are found by comparing with last sample
`timescale 1ns/100ps
`include "sadc_consts.svh"
module sadc_frame_ctrl #(
  parameter int RES_BITS   = 14,
  parameter int FRAME_BITS = 16,
  parameter bit DIFF_INPUT = 1'b1,
  parameter int WAKE_CYC   = `SADC_WAKE_CYC
) (
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                nrst,
  // Serial pins
  input  wire logic                csN,
  input  wire logic                sclk,
  input  wire logic                powerDownRequestPin,
  output      logic                sdo,
  output      logic                sdoOe,
  // Converter core
  input  wire logic [RES_BITS-1:0] rawCode,
  output      logic                sampleHold,
  output      logic                acquiring,
  output      logic                convDone,
  // Status
  output      logic                longMode,
  output      logic                frameDataValid,
  output      logic                powerDown,
  output      logic                operational
);

  // ==========================================================
  // Declarations
  sadc_ctl_if #(.W(FRAME_BITS)) ctl ();

  logic                  csPrev;
  logic                  sclkPrev;
  logic                  csFall;
  logic                  csRise;
  logic                  sclkFall;
  logic                  sclkRise;
  logic                  selected;
  logic [5:0]            fallCnt;
  logic [5:0]            next_fallCnt;
  logic                  seenRise;
  logic                  convEdge;
  logic                  longEdge;
  logic                  earlyRise;
  logic                  shortRise;
  sadc_pkg::sadc_mode_e  mode;
  logic [RES_BITS-1:0]   result;
  logic [RES_BITS-1:0]   fmtCode;
  logic [FRAME_BITS-1:0] prevWord;
  logic [FRAME_BITS-1:0] newWord;
  logic                  pdArmed;
  logic                  invalidPending;

  // ==========================================================
  // Edge detection on the serial pins
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      csPrev   <= 1'b1;
      sclkPrev <= 1'b0;
    end
    else
    begin
      csPrev   <= csN;
      sclkPrev <= sclk;
    end
  end

  assign csFall   = csPrev & ~csN;
  assign csRise   = ~csPrev & csN;
  assign sclkFall = sclkPrev & ~sclk;
  assign sclkRise = ~sclkPrev & sclk;
  assign selected = ~csPrev & ~csN;

  // ==========================================================
  // Falling edge counter, saturating so long frames never wrap
  always_comb
  begin
    next_fallCnt = fallCnt;
    if (csFall)
      next_fallCnt = '0;
    else if (selected && sclkFall && fallCnt != `SADC_FALL_SAT)
      next_fallCnt = fallCnt + 6'h01;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      fallCnt <= '0;
    else
      fallCnt <= next_fallCnt;
  end

  // Edge numbers of interest, seen as the count moves onto them or at deselect
  assign convEdge  = selected && sclkFall && (next_fallCnt == `SADC_FALL_CONV)
                     && (fallCnt != `SADC_FALL_CONV);
  assign longEdge  = selected && sclkFall && (next_fallCnt == `SADC_FALL_LONG)
                     && (fallCnt != `SADC_FALL_LONG);
  assign earlyRise = csRise && (fallCnt < `SADC_FALL_CONV);
  assign shortRise = csRise && (fallCnt >= `SADC_FALL_CONV)
                     && (fallCnt < `SADC_FALL_SHORT_MAX);

  // ==========================================================
  // First serial clock rise of the frame arms shifting
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      seenRise <= 1'b0;
    else if (csFall)
      seenRise <= 1'b0;
    else if (selected && sclkRise)
      seenRise <= 1'b1;
  end

  // ==========================================================
  // Output code format of the variant
  always_comb
  begin
    if (DIFF_INPUT)
      fmtCode = {~rawCode[RES_BITS-1], rawCode[RES_BITS-2:0]};
    else
      fmtCode = rawCode;
  end

  // Frame words, result left-justified with trailing zeros
  assign prevWord = {result, {(FRAME_BITS-RES_BITS){1'b0}}};
  assign newWord  = {fmtCode, {(FRAME_BITS-RES_BITS){1'b0}}};

  // ==========================================================
  // Conversion result store, written at the end of conversion
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      result <= '0;
    else if (convEdge)
      result <= fmtCode;
  end

  // Conversion done strobe toward the converter core
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      convDone <= 1'b0;
    else
      convDone <= convEdge;
  end

  // ==========================================================
  // Frame length mode
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      mode <= sadc_pkg::SADC_SHORT;
    else if (longEdge)
      mode <= sadc_pkg::SADC_LONG;
    else if (shortRise)
      mode <= sadc_pkg::SADC_SHORT;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      longMode <= 1'b0;
    else
      longMode <= (mode == sadc_pkg::SADC_LONG);
  end

  // ==========================================================
  // Shift register control
  // Load at select fall with the stored word (zeros in long mode), reload at fall 16 with
  // the fresh code so a held select sees it with no latency.
  always_comb
  begin
    ctl.load  = 1'b0;
    ctl.shift = 1'b0;
    ctl.word  = prevWord;
    if (csFall)
    begin
      ctl.load = 1'b1;
      if (mode == sadc_pkg::SADC_LONG)
        ctl.word = '0;
    end
    else if (convEdge)
    begin
      ctl.load = 1'b1;
      ctl.word = newWord;
    end
    else if (selected && sclkFall && seenRise)
      ctl.shift = 1'b1;
  end

  sadc_shifter #(
    .W       (FRAME_BITS)
  ) u_shifter (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .ctl     (ctl)
  );

  // ==========================================================
  // Output pin and enable
  // The bit lags the shift register by one cycle, so the enable is
  // delayed to match and no stale bit is seen at select fall.
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      sdo   <= 1'b0;
      sdoOe <= 1'b0;
    end
    else
    begin
      sdo   <= ctl.bitOut;
      sdoOe <= ~csPrev & ~csN;
    end
  end

  // ==========================================================
  // Sample and acquisition phase
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      sampleHold <= 1'b0;
    else
      sampleHold <= csFall;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      acquiring <= 1'b1;
    else if (csFall)
      acquiring <= 1'b0;
    else if (convEdge)
      acquiring <= 1'b1;
    else if (earlyRise)
      acquiring <= 1'b1;
  end

  // ==========================================================
  // Abort bookkeeping: the frame after an abort carries bad data
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      invalidPending <= 1'b0;
    else if (earlyRise)
      invalidPending <= 1'b1;
    else if (csFall)
      invalidPending <= 1'b0;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      frameDataValid <= 1'b0;
    else if (csFall)
      frameDataValid <= ~invalidPending;
  end

  // ==========================================================
  // Power-down request, read only at deselect
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      pdArmed <= 1'b0;
    else if (csRise)
      pdArmed <= powerDownRequestPin;
    else if (convEdge)
      pdArmed <= 1'b0;
  end

  // Entry at end of conversion; the shifter keeps running meanwhile.
  // Wake on a clock rise while deselected, on deselect with the pin
  // low, or on select fall so a frame never starts powered off.
  always_comb
  begin
    ctl.pdEnter = convEdge && pdArmed;
    ctl.wake    = (csN && csPrev && sclkRise)
                  || (csRise && !powerDownRequestPin)
                  || csFall;
  end

  sadc_power #(
    .WAKE_CYC (WAKE_CYC)
  ) u_power (
    .clk_sys  (clk_sys),
    .nrst     (nrst),
    .ctl      (ctl)
  );

  // ==========================================================
  // Power status outputs
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      powerDown   <= 1'b0;
      operational <= 1'b1;
    end
    else
    begin
      powerDown   <= ctl.pdState;
      operational <= ctl.ready;
    end
  end

endmodule

// ===== sim/sadc_frame_ctrl_properties.sv
// Purpose: Port timing properties of the SAR frame sequencer
// Assumes: csN and sclk stay steady for at least 2 clk_sys cycles
// Notes:   Fall count moves in step with the design; outputs are registered, hence short ranges
`timescale 1ns/100ps
module sadc_frame_ctrl_properties #(
  parameter int WAKE_CYC = 100
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // Serial pins
  input wire logic csN,
  input wire logic sclk,
  input wire logic sdoOe,
  // Core and status
  input wire logic sampleHold,
  input wire logic acquiring,
  input wire logic convDone,
  input wire logic longMode,
  input wire logic powerDown,
  input wire logic operational
);
  logic       csQ;
  logic       sclkQ;
  logic [5:0] fallCnt;
  logic [7:0] wakeCnt;
  logic       fallSeen;
  logic       csRise;
  // ==========================================================
  // Edge helpers
  assign fallSeen = sclkQ && !sclk && !csN;
  assign csRise   = !csQ && csN;
  // Last samples, same reset values as the design
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      csQ   <= 1'b1;
      sclkQ <= 1'b0;
    end
    else
    begin
      csQ   <= csN;
      sclkQ <= sclk;
    end
  end
  // Falls per frame, saturating like the design
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      fallCnt <= 6'h00;
    else if (csQ && !csN)
      fallCnt <= 6'h00;
    else if (fallSeen && fallCnt != 6'h3F)
      fallCnt <= fallCnt + 6'h01;
  end
  // Warm-up length, counted while neither down nor ready
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      wakeCnt <= 8'h00;
    else if (operational || powerDown)
      wakeCnt <= 8'h00;
    else if (wakeCnt != 8'hFF)
      wakeCnt <= wakeCnt + 8'h01;
  end
  // ==========================================================
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  oe_release_a: assert property (csN [*3] |-> !sdoOe)
    else $error("sdo driven while deselected");
  oe_drive_a: assert property ($fell(csN) |-> ##[1:3] sdoOe)
    else $error("sdo not driven after select");
  sample_pulse_a: assert property ($fell(csN) |-> ##[1:2] sampleHold ##1 !sampleHold)
    else $error("sample pulse missing or long");
  conv_end_a: assert property (fallSeen && fallCnt == 6'h0F |-> ##[1:3] convDone)
    else $error("no conversion end at fall 16");
  conv_when_a: assert property (convDone |-> fallCnt == 6'h10)
    else $error("conversion end at wrong fall");
  acq_start_a: assert property (convDone |-> ##[0:1] acquiring)
    else $error("acquisition not started");
  abort_acq_a: assert property (csRise && fallCnt < 6'h10 |-> ##[1:2] acquiring)
    else $error("abort did not restart acquisition");
  long_detect_a: assert property (fallSeen && fallCnt == 6'h1D |-> ##[1:3] longMode)
    else $error("long frame not detected");
  short_keep_a: assert property (csRise && fallCnt >= 6'h10 && fallCnt <= 6'h1C |-> ##[1:3] !longMode)
    else $error("short frame not kept");
  pd_hold_a: assert property ((!csN) [*4] ##0 powerDown |=> powerDown)
    else $error("left power-down while selected");
  pd_quiet_a: assert property (powerDown |-> !operational)
    else $error("ready while powered down");
  wake_time_a: assert property ($rose(operational) |-> wakeCnt >= WAKE_CYC - 1 && wakeCnt <= WAKE_CYC + 1)
    else $error("warm-up length wrong");
  wake_bound_a: assert property (wakeCnt <= WAKE_CYC + 2)
    else $error("warm-up never ends");
endmodule

bind sadc_frame_ctrl sadc_frame_ctrl_properties #(
  .WAKE_CYC (WAKE_CYC)
) u_props (
  .clk_sys     (clk_sys),
  .nrst        (nrst),
  .csN         (csN),
  .sclk        (sclk),
  .sdoOe       (sdoOe),
  .sampleHold  (sampleHold),
  .acquiring   (acquiring),
  .convDone    (convDone),
  .longMode    (longMode),
  .powerDown   (powerDown),
  .operational (operational)
);

// ===== sim/sadc_host_model.sv
// Purpose: Serial master model that runs one frame per call
// Assumes: Every csN and sclk edge spaced by at least 3 clk_sys cycles; request pin set together with the csN rise
// Notes:   Clock parks low between frames
`timescale 1ns/100ps
module sadc_host_model (
  // Clock
  input wire logic clk_sys,
  // Serial pins
  output     logic csN,
  output     logic sclk,
  output     logic powerDownRequestPin,
  input wire logic sdo,
  input wire logic sdoOe,
  input wire logic sdoAlt,
  // Status seen at frame end
  input wire logic powerDown
);
  // ==========================================================
  // Idle: deselected, clock low
  initial
  begin
    csN                 = 1'b1;
    sclk                = 1'b0;
    powerDownRequestPin = 1'b0;
  end
  // One frame of n falls; sdo taken just before each fall
  task automatic frame(input int n, input bit p, output logic [31:0] cap,
                       output logic [31:0] capAlt, output logic pd);
    cap = '0;
    capAlt = '0;
    @(posedge clk_sys);
    csN <= 1'b0;
    repeat (4) @(posedge clk_sys);
    for (int i = 0; i < n; i++)
    begin
      sclk <= 1'b1;
      repeat (3) @(posedge clk_sys);
      // A released pin reads as the inverse of its last level
      cap = {cap[30:0], sdoOe ? sdo : ~sdo};
      capAlt = {capAlt[30:0], sdoAlt};
      sclk <= 1'b0;
      repeat (3) @(posedge clk_sys);
    end
    repeat (6) @(posedge clk_sys);
    pd = powerDown;
    powerDownRequestPin <= p;
    csN <= 1'b1;
    repeat (3) @(posedge clk_sys);
    // Pin is read only at the rise, so flip it to catch late reads
    powerDownRequestPin <= ~p;
    repeat (17) @(posedge clk_sys);
  endtask
  // One clock pulse while deselected, wakes a powered-down converter
  task automatic wake_clk;
    @(posedge clk_sys);
    sclk <= 1'b1;
    repeat (3) @(posedge clk_sys);
    sclk <= 1'b0;
    repeat (3) @(posedge clk_sys);
  endtask
endmodule

// ===== sim/testbench.sv
// Purpose: Self-checking bench for the SAR frame sequencer
// Assumes: Both code variants on shared pins, short warm-up
// Notes:   Frame table walks modes, abort and power-down
`timescale 1ns/100ps
module testbench;
  localparam int WAKE = 4;
  logic        clk_sys;
  logic        nrst;
  logic        csN;
  logic        sclk;
  logic        powerDownRequestPin;
  logic        sdo;
  logic        sdoOe;
  logic        sdoSe;
  logic [13:0] rawCode;
  logic        longMode;
  logic        frameDataValid;
  logic        powerDown;
  logic        operational;
  int          n_fail;
  int          checked;
  int          nTab[14] = '{16, 20, 32, 29, 16, 8, 16, 16, 16, 32, 32, 32, 28, 16};
  bit          pTab[14] = '{0, 0, 0, 0, 0, 0, 0, 1, 0, 1, 1, 0, 0, 0};
  // ==========================================================
  // Clock
  initial
  begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  sadc_host_model u_sadc_host_model (
    .clk_sys             (clk_sys),
    .csN                 (csN),
    .sclk                (sclk),
    .powerDownRequestPin (powerDownRequestPin),
    .sdo                 (sdo),
    .sdoOe               (sdoOe),
    .sdoAlt              (sdoSe),
    .powerDown           (powerDown)
  );
  sadc_frame_ctrl #(
    .DIFF_INPUT (1'b1),
    .WAKE_CYC   (WAKE)
  ) u_sadc_frame_ctrl (
    .clk_sys             (clk_sys),
    .nrst                (nrst),
    .csN                 (csN),
    .sclk                (sclk),
    .powerDownRequestPin (powerDownRequestPin),
    .sdo                 (sdo),
    .sdoOe               (sdoOe),
    .rawCode             (rawCode),
    .sampleHold          (),
    .acquiring           (),
    .convDone            (),
    .longMode            (longMode),
    .frameDataValid      (frameDataValid),
    .powerDown           (powerDown),
    .operational         (operational)
  );
  // Single-ended variant on the same pins, for the straight binary code
  sadc_frame_ctrl #(
    .DIFF_INPUT (1'b0),
    .WAKE_CYC   (WAKE)
  ) u_sadc_frame_ctrl_se (
    .clk_sys             (clk_sys),
    .nrst                (nrst),
    .csN                 (csN),
    .sclk                (sclk),
    .powerDownRequestPin (powerDownRequestPin),
    .sdo                 (sdoSe),
    .sdoOe               (),
    .rawCode             (rawCode),
    .sampleHold          (),
    .acquiring           (),
    .convDone            (),
    .longMode            (),
    .frameDataValid      (),
    .powerDown           (),
    .operational         ()
  );
  // ==========================================================
  // Reporting
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    checked++;
    if (got !== exp)
    begin
      n_fail++;
      $display("mismatch at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Guard against a stuck run
  initial
  begin
    repeat (100000) @(posedge clk_sys);
    n_fail++;
    $display("mismatch at %0t: run too long", $time);
    close_out();
  end
  // ==========================================================
  // Main sequence with reference model
  initial
  begin
    logic [31:0] cap;
    logic [31:0] capS;
    logic [31:0] e;
    logic [31:0] eS;
    logic [31:0] m;
    logic [15:0] prevW;
    logic [15:0] newW;
    logic [15:0] prevS;
    logic [15:0] newS;
    logic [13:0] code;
    logic        pdS;
    logic        pdE;
    logic        pdArm;
    logic        longM;
    logic        haveW;
    logic        okW;
    logic        b;
    n_fail = 0;
    checked = 0;
    nrst = 1'b0;
    rawCode = 14'h0000;
    prevW = 16'h0000;
    prevS = 16'h0000;
    pdArm = 1'b0;
    longM = 1'b0;
    haveW = 1'b0;
    okW = 1'b1;
    void'($urandom(99));
    repeat (12) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    for (int f = 0; f < 14; f++)
    begin
      code = 14'($urandom);
      rawCode <= code;
      newW = {~code[13], code[12:0], 2'h0};
      newS = {code, 2'h0};
      u_sadc_host_model.frame(nTab[f], pTab[f], cap, capS, pdS);
      e = '0;
      eS = '0;
      m = '0;
      for (int i = 0; i < nTab[f]; i++)
      begin
        b = (i < 16) ? (!longM && prevW[15 - i]) : newW[31 - i];
        e = {e[30:0], b};
        b = (i < 16) ? (!longM && prevS[15 - i]) : newS[31 - i];
        eS = {eS[30:0], b};
        m = {m[30:0], (i >= 16) || (haveW && okW)};
      end
      check(cap & m, e & m, "serial word");
      check(capS & m, eS & m, "straight word");
      if (haveW)
        check(32'(frameDataValid), 32'(okW), "valid flag");
      pdE = (nTab[f] >= 16) && pdArm;
      check(32'(pdS), 32'(pdE), "power down");
      pdArm = pTab[f];
      okW = nTab[f] >= 16;
      if (nTab[f] >= 16)
      begin
        prevW = newW;
        prevS = newS;
        haveW = 1'b1;
        if (nTab[f] >= 30)
          longM = 1'b1;
        else if (nTab[f] <= 28)
          longM = 1'b0;
      end
      check(32'(longMode), 32'(longM), "frame mode");
      check(32'(operational), 32'(!(pdE && pTab[f])), "ready");
      // Still down after deselect: a clock rise alone must wake it
      if (pdE && pTab[f])
      begin
        u_sadc_host_model.wake_clk();
        repeat (12) @(posedge clk_sys);
        check(32'(operational), 32'h1, "clock wake");
        check(32'(powerDown), 32'h0, "wake state");
      end
    end
    close_out();
  end
endmodule
